// ==== cmsq_pkg.sv ====
// Behaviour
// - Continuous mode stores result, restarts immediately.
// - Continuous mode: start/busy reads one.
// - Single-shot idles powered down until start.
// - Start powers core, runs exactly one conversion.
// - Single-shot done: store, clear flag, power down.
// - Start during running conversion is ignored.
// - Continuous to single: finish, clear, power down.
// - Power-up reset restores configuration defaults.
// - General-call reset equals power-up reset.
// - Timing from internal oscillator only.
// - Sampling oscillator nominally 275 kHz.
// - Result is 12-bit differential sample.
// - General call 00h then 06h, both acknowledged.
// - General-call reset aborts, zeroes result, defaults.
// - Output 16-bit two's complement, sign-extended.
// - Output reads zero until first conversion.
package cmsq_pkg;
	localparam int unsigned CLK_HZ        = 25000000;
	localparam int unsigned OSC_HZ        = 275000;
	localparam int unsigned RATE_SPS      = 128;
	// Oscillator tick divider, rounded down to whole clock cycles.
	localparam int unsigned OSC_DIV       = CLK_HZ / OSC_HZ;
	// Oscillator ticks per conversion period.
	localparam int unsigned TICKS_PER_CNV = OSC_HZ / RATE_SPS;
	localparam int unsigned RES_BITS      = 12;
	localparam int unsigned OUT_BITS      = 16;
	localparam logic [7:0]  GC_ADDR       = 8'h00;
	localparam logic [7:0]  GC_RESET      = 8'h06;
	localparam logic        MODE_DEFAULT  = 1'b0;
	localparam logic        FLAG_DEFAULT  = 1'b0;
	localparam logic [15:0] OUT_RESET     = 16'h0000;
endpackage

// ==== cmsq_div.sv ====
`timescale 1ns/1ps
module cmsq_div
	import cmsq_pkg::*;
#(
	parameter int unsigned DIV = 2
)(
	// Clock and reset.
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Enable and tick.
	input  wire logic en_i,
	output logic      tick_o
);
	localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	logic [W-1:0] cnt;

	// Free divider; restarts while disabled so each run is whole periods.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || !en_i)
		begin
			cnt    <= '0;
			tick_o <= 1'b0;
		end
		else
		begin
			tick_o <= (cnt == LAST);
			cnt    <= (cnt == LAST) ? '0 : cnt + W'(1);
		end
	end
endmodule

// ==== cmsq_top.sv ====
`timescale 1ns/1ps
module cmsq_top
	import cmsq_pkg::*;
#(
	parameter int unsigned CONV_TICKS = TICKS_PER_CNV
)(
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// Configuration writes from the serial slave.
	input  wire logic        cfg_wr_i,
	input  wire logic        cfg_mode_single_i,
	input  wire logic        cfg_start_i,
	// Received bus bytes from the serial slave.
	input  wire logic        byte_valid_i,
	input  wire logic        byte_is_addr_i,
	input  wire logic [7:0]  byte_i,
	// Converter core.
	input  wire logic [11:0] sample_i,
	// Status and result.
	output logic             ack_o,
	output logic             start_busy_flag_o,
	output logic             mode_single_o,
	output logic             core_power_o,
	output logic             conv_done_o,
	output logic [15:0]      result_o
);
	localparam int unsigned CW = $clog2(CONV_TICKS + 1);
	localparam logic [CW-1:0] CLAST = CW'(CONV_TICKS - 1);

	logic          osc_tick;
	logic          running;
	logic [CW-1:0] tcnt;
	logic          gc_armed;
	logic          gc_reset;
	logic          srst_n;
	logic          conv_end;

	// Internal sampling oscillator; no external conversion clock exists.
	cmsq_div #(.DIV(OSC_DIV)) u_osc (
		.clk_i   (clk_i),
		.rst_n_i (srst_n),
		.en_i    (core_power_o),
		.tick_o  (osc_tick)
	);

	// General call detect: 00h address then 06h data.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			gc_armed <= 1'b0;
			gc_reset <= 1'b0;
			ack_o    <= 1'b0;
		end
		else
		begin
			gc_reset <= 1'b0;
			ack_o    <= 1'b0;
			if (byte_valid_i)
			begin
				if (byte_is_addr_i)
				begin
					gc_armed <= (byte_i == GC_ADDR);
					ack_o    <= (byte_i == GC_ADDR);
				end
				else if (gc_armed && byte_i == GC_RESET)
				begin
					gc_armed <= 1'b0;
					gc_reset <= 1'b1;
					ack_o    <= 1'b1;
				end
				else
					gc_armed <= 1'b0;
			end
		end
	end

	// General call acts exactly as a power-up reset.
	assign srst_n   = rst_n_i && !gc_reset;
	assign conv_end = running && osc_tick && (tcnt == CLAST);

	// Mode register; default after any reset.
	always_ff @(posedge clk_i)
	begin
		if (!srst_n)
			mode_single_o <= MODE_DEFAULT;
		else if (cfg_wr_i)
			mode_single_o <= cfg_mode_single_i;
	end

	// Conversion sequencer: period counted in oscillator ticks.
	always_ff @(posedge clk_i)
	begin
		if (!srst_n)
		begin
			running      <= 1'b0;
			tcnt         <= '0;
			core_power_o <= 1'b0;
		end
		else
		begin
			if (conv_end)
			begin
				tcnt <= '0;
				// Continuous restarts at once; single-shot powers down.
				running      <= !mode_single_o;
				core_power_o <= !mode_single_o;
			end
			else if (running && osc_tick)
				tcnt <= tcnt + CW'(1);
			else if (!running)
			begin
				// Idle until started, or continuous selected.
				if (!mode_single_o || (cfg_wr_i && cfg_start_i))
				begin
					running      <= 1'b1;
					core_power_o <= 1'b1;
				end
			end
		end
	end

	// Start/busy flag; writes while running change nothing.
	always_ff @(posedge clk_i)
	begin
		if (!srst_n)
			start_busy_flag_o <= FLAG_DEFAULT;
		else if (!mode_single_o)
			start_busy_flag_o <= 1'b1;
		else if (conv_end)
			start_busy_flag_o <= 1'b0;
		else if (!running && cfg_wr_i && cfg_start_i)
			start_busy_flag_o <= 1'b1;
		else if (!running)
			start_busy_flag_o <= 1'b0;
	end

	// Result loaded whole, sign-extended from 12 bits.
	always_ff @(posedge clk_i)
	begin
		if (!srst_n)
		begin
			result_o    <= OUT_RESET;
			conv_done_o <= 1'b0;
		end
		else
		begin
			conv_done_o <= conv_end;
			if (conv_end)
				result_o <= {{(OUT_BITS-RES_BITS){sample_i[RES_BITS-1]}}, sample_i};
		end
	end

	// Cycles since the last oscillator tick, kept only for the spacing check below.
	localparam int unsigned GW = $clog2(OSC_DIV) + 1;
	logic [GW-1:0] tick_gap;
	logic          tick_seen;

	// Cleared while the core is off, as the divider is, so a restart never looks like a short period.
	always_ff @(posedge clk_i)
	begin
		if (!srst_n || !core_power_o)
		begin
			tick_gap  <= '0;
			tick_seen <= 1'b0;
		end
		else if (osc_tick)
		begin
			tick_gap  <= GW'(1);
			tick_seen <= 1'b1;
		end
		else if (tick_gap != '1)
			tick_gap <= tick_gap + GW'(1); // Saturates so a stalled divider cannot wrap into a pass.
	end

	// Checks; each one names the rule that it guards.
	a_cont_busy_one: assert property (@(posedge clk_i) disable iff (!srst_n)
		!$past(mode_single_o) && !mode_single_o && $past(srst_n) |-> start_busy_flag_o)
		else $error("busy flag low in continuous mode");
	a_single_off: assert property (@(posedge clk_i) disable iff (!srst_n)
		mode_single_o && !running && !(cfg_wr_i && cfg_start_i) |=> !core_power_o)
		else $error("core powered while idle");
	a_idle_flag_low: assert property (@(posedge clk_i) disable iff (!srst_n)
		mode_single_o && !running && !(cfg_wr_i && cfg_start_i) |=> !start_busy_flag_o)
		else $error("busy flag set while idle");
	a_start_runs: assert property (@(posedge clk_i) disable iff (!srst_n)
		mode_single_o && !running && cfg_wr_i && cfg_start_i |=> running && core_power_o)
		else $error("start did not begin conversion");
	a_done_down: assert property (@(posedge clk_i) disable iff (!srst_n)
		conv_end && mode_single_o && !cfg_wr_i |=> !start_busy_flag_o && !core_power_o)
		else $error("single shot did not power down");
	a_no_restart: assert property (@(posedge clk_i) disable iff (!srst_n)
		running && !osc_tick |=> tcnt == $past(tcnt))
		else $error("running conversion restarted");
	a_run_holds: assert property (@(posedge clk_i) disable iff (!srst_n)
		running && !conv_end |=> running && core_power_o)
		else $error("conversion stopped before its end");
	a_cont_restart: assert property (@(posedge clk_i) disable iff (!srst_n)
		conv_end && !mode_single_o |=> running)
		else $error("continuous did not restart");
	a_osc_spacing: assert property (@(posedge clk_i) disable iff (!srst_n)
		osc_tick && tick_seen |-> tick_gap == GW'(OSC_DIV))
		else $error("oscillator tick spacing wrong");
	a_gc_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		gc_reset |=> result_o == OUT_RESET && !running && mode_single_o == MODE_DEFAULT)
		else $error("general call reset incomplete");
	a_gc_ack: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		byte_valid_i && byte_is_addr_i && byte_i == GC_ADDR |=> ack_o)
		else $error("general call address not acknowledged");
	a_result_reset: assert property (@(posedge clk_i)
		!srst_n |=> result_o == OUT_RESET && !conv_done_o)
		else $error("result not cleared by reset");
	a_result_sext: assert property (@(posedge clk_i) disable iff (!srst_n)
		conv_end |=> result_o == {{4{$past(sample_i[11])}}, $past(sample_i)})
		else $error("result not sign extended");
	a_result_hold: assert property (@(posedge clk_i) disable iff (!srst_n)
		!conv_end && $past(srst_n) |=> $stable(result_o))
		else $error("result changed without conversion");
	a_done_pulse: assert property (@(posedge clk_i) disable iff (!srst_n)
		conv_end |=> conv_done_o ##1 !conv_done_o)
		else $error("done pulse not one cycle");
	c_single: cover property (@(posedge clk_i) conv_end && mode_single_o);
	c_cont: cover property (@(posedge clk_i) conv_end && !mode_single_o);
	c_gc: cover property (@(posedge clk_i) gc_reset);
	c_switch: cover property (@(posedge clk_i) running && $fell(!mode_single_o));
	c_start_busy: cover property (@(posedge clk_i) running && mode_single_o && cfg_wr_i && cfg_start_i);
endmodule

// ==== cmsq_bus_model.sv ====
`timescale 1ns/1ps
module cmsq_bus_model
(
	// Clock and acknowledge.
	input  wire logic  clk_i,
	input  wire logic  ack_i,
	// Received byte towards the block.
	output logic       byte_valid_o,
	output logic       byte_is_addr_o,
	output logic [7:0] byte_o
);
	// All byte lines idle low from time zero.
	initial
	begin
		byte_valid_o = 1'b0;
		byte_is_addr_o = 1'b0;
		byte_o = 8'h00;
	end
	// One byte per call; a released byte shows its inverse so a stale value never looks fresh.
	task automatic send_byte(input logic is_addr, input logic [7:0] val, output logic acked);
		@(negedge clk_i);
		byte_valid_o = 1'b1;
		byte_is_addr_o = is_addr;
		byte_o = val;
		@(negedge clk_i);
		byte_valid_o = 1'b0;
		byte_o = ~val;
		acked = ack_i;
	endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench
	import cmsq_pkg::*;
;
	localparam int unsigned CONV_TICKS = 4;
	logic        clk_i, rst_n_i, cfg_wr_i, cfg_mode_single_i, cfg_start_i, acked;
	logic        byte_valid_i, byte_is_addr_i, ack_o, start_busy_flag_o, mode_single_o, core_power_o, conv_done_o;
	logic [7:0]  byte_i;
	logic [11:0] sample_i;
	logic [15:0] result_o;
	int          n_fail, samples_checked, seed, k, n_done, k0;
	cmsq_top #(.CONV_TICKS(CONV_TICKS)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr_i),
		.cfg_mode_single_i(cfg_mode_single_i), .cfg_start_i(cfg_start_i), .byte_valid_i(byte_valid_i),
		.byte_is_addr_i(byte_is_addr_i), .byte_i(byte_i), .sample_i(sample_i), .ack_o(ack_o),
		.start_busy_flag_o(start_busy_flag_o), .mode_single_o(mode_single_o), .core_power_o(core_power_o),
		.conv_done_o(conv_done_o), .result_o(result_o));
	cmsq_bus_model bus_u (.clk_i(clk_i), .ack_i(ack_o), .byte_valid_o(byte_valid_i),
		.byte_is_addr_o(byte_is_addr_i), .byte_o(byte_i));
	// Free-running 25 MHz clock.
	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	// Counting done pulses catches restarts and queued conversions.
	always @(posedge clk_i)
		if (conv_done_o === 1'b1)
			n_done++;
	function automatic logic [15:0] sext(input logic [11:0] s);
		return {{4{s[11]}}, s};
	endfunction
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
		samples_checked++;
		if (seen !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
			n_fail++;
		end
	endtask
	task automatic print_verdict();
		if (n_fail == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wait_done();
		@(negedge clk_i);
		for (k = 0; k < 1000 && conv_done_o !== 1'b1; k++)
			@(negedge clk_i);
		if (k == 1000)
		begin
			$display("[ERR] conv_done expected 1 seen 0");
			n_fail++;
			print_verdict();
		end
	endtask
	task automatic cfg(input logic single, input logic start);
		@(negedge clk_i);
		cfg_wr_i = 1'b1;
		cfg_mode_single_i = single;
		cfg_start_i = start;
		@(negedge clk_i);
		cfg_wr_i = 1'b0;
	endtask
	// Main sequence: continuous, mode switch, single shot, general call.
	initial
	begin
		{rst_n_i, cfg_wr_i, cfg_mode_single_i, cfg_start_i} = 4'h0;
		{n_fail, samples_checked} = '0;
		seed = 32'h2c5f;
		sample_i = 12'h800;
		repeat (8) @(negedge clk_i);
		chk("res_rst", OUT_RESET, result_o);
		chk("mode_rst", 16'(MODE_DEFAULT), 16'(mode_single_o));
		rst_n_i = 1'b1;
		repeat (3)
		begin
			wait_done();
			chk("cont_res", sext(sample_i), result_o);
			chk("cont_flag", 16'h0001, 16'(start_busy_flag_o));
			chk("cont_pwr", 16'h0001, 16'(core_power_o));
			sample_i = 12'($random(seed));
		end
		repeat (50) @(negedge clk_i);
		cfg(1'b1, 1'b0);
		wait_done();
		chk("sw_res", sext(sample_i), result_o);
		chk("sw_flag", 16'h0000, 16'(start_busy_flag_o));
		chk("sw_pwr", 16'h0000, 16'(core_power_o));
		k0 = n_done;
		repeat (500) @(negedge clk_i);
		chk("idle_cnt", 16'h0001, 16'(n_done - k0));
		chk("idle_pwr", 16'h0000, 16'(core_power_o));
		sample_i = 12'h7ff;
		cfg(1'b1, 1'b1);
		chk("shot_pwr", 16'h0001, 16'(core_power_o));
		chk("shot_flag", 16'h0001, 16'(start_busy_flag_o));
		k0 = n_done;
		repeat (100) @(negedge clk_i);
		cfg(1'b1, 1'b1);
		wait_done();
		chk("shot_res", 16'h07ff, result_o);
		chk("shot_flag0", 16'h0000, 16'(start_busy_flag_o));
		chk("shot_pwr0", 16'h0000, 16'(core_power_o));
		repeat (500) @(negedge clk_i);
		chk("shot_cnt", 16'h0001, 16'(n_done - k0));
		sample_i = 12'($random(seed));
		cfg(1'b1, 1'b1);
		repeat (100) @(negedge clk_i);
		bus_u.send_byte(1'b1, 8'h00, acked);
		chk("gc_ack_a", 16'h0001, 16'(acked));
		bus_u.send_byte(1'b0, 8'h05, acked);
		chk("gc_nak_d", 16'h0000, 16'(acked));
		bus_u.send_byte(1'b1, 8'h00, acked);
		chk("gc_ack_a1", 16'h0001, 16'(acked));
		bus_u.send_byte(1'b1, 8'h3c, acked);
		chk("gc_nak_a", 16'h0000, 16'(acked));
		bus_u.send_byte(1'b0, 8'h06, acked);
		chk("gc_nak_ord", 16'h0000, 16'(acked));
		chk("gc_nak_mode", 16'h0001, 16'(mode_single_o));
		bus_u.send_byte(1'b1, 8'h00, acked);
		chk("gc_ack_a2", 16'h0001, 16'(acked));
		bus_u.send_byte(1'b0, 8'h06, acked);
		chk("gc_ack_d", 16'h0001, 16'(acked));
		repeat (2) @(negedge clk_i);
		chk("gc_res", OUT_RESET, result_o);
		chk("gc_mode", 16'(MODE_DEFAULT), 16'(mode_single_o));
		wait_done();
		chk("gc_cont_res", sext(sample_i), result_o);
		chk("gc_cont_flag", 16'h0001, 16'(start_busy_flag_o));
		print_verdict();
	end
endmodule
